// ===== design/prox_afe_pkg.sv
// Package: register map, field positions, reset values and carrier types for the proximity front end
package prox_afe_pkg;

  // Register word offsets (byte address = 4 x index)
  localparam logic [3:0] SW_C_IDX    = 4'h0;
  localparam logic [3:0] SW_D_IDX    = 4'h1;
  localparam logic [3:0] CTRL0_IDX   = 4'h2;
  localparam logic [3:0] CTRL1_IDX   = 4'h3;
  localparam logic [3:0] DAC_IDX     = 4'h4;
  localparam logic [3:0] AMP1_IDX    = 4'h5;
  localparam logic [3:0] AMP2_IDX    = 4'h6;
  localparam logic [3:0] CMPCAL_IDX  = 4'h7;
  localparam logic [3:0] ROUTE_IDX   = 4'h8;
  localparam int         ADDR_W      = 6;

  // Field positions
  localparam int SW_D_W         = 5;
  localparam int C0_AMP2_EN     = 7;
  localparam int C0_AMP1_EN     = 6;
  localparam int C0_CMP_EN      = 5;
  localparam int C0_EDGE_HI     = 4;
  localparam int C0_EDGE_LO     = 3;
  localparam int C0_DEB_HI      = 2;
  localparam int C1_AMP2_OUT    = 7;
  localparam int C1_AMP1_OUT    = 6;
  localparam int C1_HYS_HI      = 5;
  localparam int C1_HYS_LO      = 4;
  localparam int C1_BIAS_HI     = 3;
  localparam int C1_BIAS_LO     = 2;
  localparam int C1_AMP2_SPEED  = 1;
  localparam int C1_AMP1_SPEED  = 0;
  localparam int AC_MODE        = 7;
  localparam int AC_REF         = 6;
  localparam int CC_RESULT      = 7;
  localparam int CC_MODE        = 6;
  localparam int CC_REF         = 5;

  // Reset values
  localparam logic [7:0] SW_RESET     = 8'h00;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] DAC_RESET    = 8'h00;
  localparam logic [7:0] AMP_CAL_RST  = 8'h20;
  localparam logic [5:0] CMP_CAL_RST  = 6'h10;

  // Edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Debounce unit time: one system clock period
  localparam int debounce_unit_time_ns = 100;
  localparam int CLK_PERIOD_NS         = 100;
  localparam int DEB_UNIT_CYC          = (debounce_unit_time_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEB_CNT_W             = 8;

  typedef struct packed {
    logic [7:0] sw_c;
    logic [4:0] sw_d;
    logic [7:0] ctrl0;
    logic [5:0] ctrl1;     // bits 5..0 writable
    logic [7:0] dac;
    logic [7:0] amp1_cal;
    logic [7:0] amp2_cal;
    logic [6:0] cmp_cal;   // bits 6..0 writable
    logic       capture_source_select;
  } regs_t;

  typedef struct packed {
    logic       amp_second_enable;
    logic       amp_first_enable;
    logic       comparator_dac_enable;
    logic [1:0] comparator_hysteresis;
    logic [1:0] comparator_bias;
    logic       amp_second_speed;
    logic       amp_first_speed;
    logic [7:0] dac_code;
    logic       amp_first_cal_mode;
    logic       amp_first_cal_ref;
    logic [5:0] amp_first_trim;
    logic       amp_second_cal_mode;
    logic       amp_second_cal_ref;
    logic [5:0] amp_second_trim;
    logic       comparator_cal_mode;
    logic       comparator_cal_ref_select;
    logic [4:0] comparator_trim;
  } analog_ctrl_t;

endpackage : prox_afe_pkg

// ===== design/proximity_afe_control.sv
// Digital control and comparator filter for the proximity sensing analog chain
// Functional notes
// - Switch bit 1 closes, 0 opens; reset open
// - Bank D bits 7..5 read zero
// - Second amp disabled, output tri-stated when off
// - First amp disabled, output tri-stated when off
// - Comparator off forces low, DAC tri-stated
// - Edge field: none, rise, fall, both
// - Debounce code n gives 2^n-1..2^n cycles
// - Control 1 bits 7,6 read amp outputs
// - Hysteresis and bias fields drive comparator
// - Speed bits: 0 low current, 1 bandwidth
// - Eight-bit DAC code, resets to zero
// - Amp cal bit 7 selects calibration mode
// - Amp cal bit 6 selects reference input
// - Six-bit amp trim resets to 100000
// - Comparator result bit, zero when disabled
// - Comparator mode, reference, five-bit trim 10000
// - Selected filtered edge raises interrupt request
// - Filtered signal routable to timer capture
`timescale 1ns/1ps
`default_nettype none

module proximity_afe_control (
  input  wire logic                             ref_clk,               // System clock, 10 MHz
  input  wire logic                             resetn,                // Async reset, active low
  input  wire logic [prox_afe_pkg::ADDR_W-1:0]  avs_address,           // Byte address
  input  wire logic                             avs_read,              // Read request
  input  wire logic                             avs_write,             // Write request
  input  wire logic [31:0]                      avs_writedata,         // Write data
  input  wire logic [3:0]                       avs_byteenable,        // Byte lanes
  output logic [31:0]                           avs_readdata,          // Read data
  output logic                                  avs_waitrequest,       // Stall
  output logic [1:0]                            avs_response,          // 00 okay, 10 slave error
  output logic [7:0]                            switch_c_close,        // Switches 16..23 closed
  output logic [4:0]                            switch_d_close,        // Switches 24..28 closed
  output prox_afe_pkg::analog_ctrl_t            analog_ctrl,           // Enables, trims, settings
  output logic                                  amp_first_out_oe_n,    // Low: first amp drives pin
  output logic                                  amp_second_out_oe_n,   // Low: second amp drives pin
  output logic                                  dac_out_oe_n,          // Low: DAC drives output
  input  wire logic                             comparator_raw,        // Analog comparator decision
  input  wire logic                             amp_first_cal_out,     // First amp output in cal
  input  wire logic                             amp_second_cal_out,    // Second amp output in cal
  output logic                                  comparator_result,     // Filtered decision
  output logic                                  proximity_irq,         // One-cycle edge pulse
  output logic                                  timer_capture_input    // Routed to timer capture
);

  typedef struct packed {
    prox_afe_pkg::regs_t regs;
    logic [2:0]          cmp_sync;
    logic [2:0]          a1_sync;
    logic [2:0]          a2_sync;
    logic                cmp_in;
    logic                amp1_in;
    logic                amp2_in;
    logic [prox_afe_pkg::DEB_CNT_W-1:0] deb_cnt;
    logic                filt;
    logic                filt_d;
    logic                irq;
    logic                ack;
    logic [31:0]         rdata;
    logic [1:0]          resp;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  localparam state_t STATE_RESET = '{
    regs: '{sw_c: prox_afe_pkg::SW_RESET, sw_d: prox_afe_pkg::SW_RESET[4:0],
            ctrl0: prox_afe_pkg::CTRL_RESET, ctrl1: prox_afe_pkg::CTRL_RESET[5:0],
            dac: prox_afe_pkg::DAC_RESET, amp1_cal: prox_afe_pkg::AMP_CAL_RST,
            amp2_cal: prox_afe_pkg::AMP_CAL_RST, cmp_cal: {1'b0, prox_afe_pkg::CMP_CAL_RST},
            capture_source_select: 1'b0},
    default: '0
  };

  logic [3:0]  idx;
  logic        mapped;
  logic [7:0]  wb;
  logic [2:0]  deb_code;
  logic [prox_afe_pkg::DEB_CNT_W-1:0] deb_target;
  logic [31:0] deb_span;
  logic        cmp_live;
  logic        cmp_en;
  logic [1:0]  edge_sel;

  assign idx      = avs_address[prox_afe_pkg::ADDR_W-1:2];
  assign mapped   = (idx <= prox_afe_pkg::ROUTE_IDX);
  assign wb       = avs_writedata[7:0];
  assign cmp_en   = state_r.regs.ctrl0[prox_afe_pkg::C0_CMP_EN];
  assign deb_code = state_r.regs.ctrl0[prox_afe_pkg::C0_DEB_HI:0];
  assign edge_sel = state_r.regs.ctrl0[prox_afe_pkg::C0_EDGE_HI:prox_afe_pkg::C0_EDGE_LO];
  // Disabled comparator reads as low before filtering
  assign cmp_live = state_r.cmp_in & cmp_en;
  // Count reaching 2^n-1 after the last change; sampling jitter adds up to one cycle
  assign deb_span   = ((32'h1 << deb_code) - 32'h1) * 32'(prox_afe_pkg::DEB_UNIT_CYC);
  assign deb_target = deb_span[prox_afe_pkg::DEB_CNT_W-1:0];

  always_comb begin
    state_nxt       = state_r;
    state_nxt.ack   = 1'b0;
    state_nxt.irq   = 1'b0;
    // Three-stage capture; a change counts once stages two and three agree
    state_nxt.cmp_sync = {state_r.cmp_sync[1:0], comparator_raw};
    state_nxt.a1_sync  = {state_r.a1_sync[1:0], amp_first_cal_out};
    state_nxt.a2_sync  = {state_r.a2_sync[1:0], amp_second_cal_out};
    if (state_r.cmp_sync[2] == state_r.cmp_sync[1]) begin
      state_nxt.cmp_in = state_r.cmp_sync[2];
    end
    if (state_r.a1_sync[2] == state_r.a1_sync[1]) begin
      state_nxt.amp1_in = state_r.a1_sync[2];
    end
    if (state_r.a2_sync[2] == state_r.a2_sync[1]) begin
      state_nxt.amp2_in = state_r.a2_sync[2];
    end

    // Debounce filter
    if (deb_code == 3'h0) begin
      state_nxt.filt    = cmp_live;
      state_nxt.deb_cnt = '0;
    end else if (cmp_live == state_r.filt) begin
      state_nxt.deb_cnt = '0;
    end else if (state_r.deb_cnt >= deb_target) begin
      state_nxt.filt    = cmp_live;
      state_nxt.deb_cnt = '0;
    end else begin
      state_nxt.deb_cnt = state_r.deb_cnt + 1'b1;
    end
    state_nxt.filt_d = state_r.filt;

    case (edge_sel)
      prox_afe_pkg::EDGE_RISE: state_nxt.irq = state_r.filt & ~state_r.filt_d;
      prox_afe_pkg::EDGE_FALL: state_nxt.irq = ~state_r.filt & state_r.filt_d;
      prox_afe_pkg::EDGE_BOTH: state_nxt.irq = state_r.filt ^ state_r.filt_d;
      default:                 state_nxt.irq = 1'b0;
    endcase

    // Bus: every access answered one cycle after it is seen
    if ((avs_read | avs_write) & ~state_r.ack) begin
      state_nxt.ack   = 1'b1;
      state_nxt.rdata = '0;
      state_nxt.resp  = mapped ? 2'h0 : 2'h2;
      if (avs_write & avs_byteenable[0]) begin
        case (idx)
          prox_afe_pkg::SW_C_IDX:   state_nxt.regs.sw_c = wb;
          prox_afe_pkg::SW_D_IDX:   state_nxt.regs.sw_d = wb[prox_afe_pkg::SW_D_W-1:0];
          prox_afe_pkg::CTRL0_IDX:  state_nxt.regs.ctrl0 = wb;
          prox_afe_pkg::CTRL1_IDX:  state_nxt.regs.ctrl1 = wb[5:0];
          prox_afe_pkg::DAC_IDX:    state_nxt.regs.dac = wb;
          prox_afe_pkg::AMP1_IDX:   state_nxt.regs.amp1_cal = wb;
          prox_afe_pkg::AMP2_IDX:   state_nxt.regs.amp2_cal = wb;
          prox_afe_pkg::CMPCAL_IDX: state_nxt.regs.cmp_cal = wb[6:0];
          prox_afe_pkg::ROUTE_IDX:  state_nxt.regs.capture_source_select = wb[0];
          default: ;
        endcase
      end
      if (avs_read) begin
        case (idx)
          prox_afe_pkg::SW_C_IDX:   state_nxt.rdata[7:0] = state_r.regs.sw_c;
          prox_afe_pkg::SW_D_IDX:   state_nxt.rdata[7:0] = {3'h0, state_r.regs.sw_d};
          prox_afe_pkg::CTRL0_IDX:  state_nxt.rdata[7:0] = state_r.regs.ctrl0;
          // Amp outputs only meaningful in calibration; zero otherwise
          prox_afe_pkg::CTRL1_IDX:  state_nxt.rdata[7:0] = {state_r.amp2_in & state_r.regs.amp2_cal[7],
                                                           state_r.amp1_in & state_r.regs.amp1_cal[7],
                                                           state_r.regs.ctrl1};
          prox_afe_pkg::DAC_IDX:    state_nxt.rdata[7:0] = state_r.regs.dac;
          prox_afe_pkg::AMP1_IDX:   state_nxt.rdata[7:0] = state_r.regs.amp1_cal;
          prox_afe_pkg::AMP2_IDX:   state_nxt.rdata[7:0] = state_r.regs.amp2_cal;
          prox_afe_pkg::CMPCAL_IDX: state_nxt.rdata[7:0] = {cmp_live, state_r.regs.cmp_cal};
          prox_afe_pkg::ROUTE_IDX:  state_nxt.rdata[7:0] = {7'h0, state_r.regs.capture_source_select};
          default:                  state_nxt.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= STATE_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~state_r.ack;
  assign avs_readdata    = state_r.rdata;
  assign avs_response    = state_r.resp;
  assign switch_c_close  = state_r.regs.sw_c;
  assign switch_d_close  = state_r.regs.sw_d;

  always_comb begin
    analog_ctrl.amp_second_enable         = state_r.regs.ctrl0[prox_afe_pkg::C0_AMP2_EN];
    analog_ctrl.amp_first_enable          = state_r.regs.ctrl0[prox_afe_pkg::C0_AMP1_EN];
    analog_ctrl.comparator_dac_enable     = cmp_en;
    analog_ctrl.comparator_hysteresis     = state_r.regs.ctrl1[prox_afe_pkg::C1_HYS_HI:prox_afe_pkg::C1_HYS_LO];
    analog_ctrl.comparator_bias           = state_r.regs.ctrl1[prox_afe_pkg::C1_BIAS_HI:prox_afe_pkg::C1_BIAS_LO];
    analog_ctrl.amp_second_speed          = state_r.regs.ctrl1[prox_afe_pkg::C1_AMP2_SPEED];
    analog_ctrl.amp_first_speed           = state_r.regs.ctrl1[prox_afe_pkg::C1_AMP1_SPEED];
    analog_ctrl.dac_code                  = state_r.regs.dac;
    analog_ctrl.amp_first_cal_mode        = state_r.regs.amp1_cal[prox_afe_pkg::AC_MODE];
    analog_ctrl.amp_first_cal_ref         = state_r.regs.amp1_cal[prox_afe_pkg::AC_REF];
    analog_ctrl.amp_first_trim            = state_r.regs.amp1_cal[5:0];
    analog_ctrl.amp_second_cal_mode       = state_r.regs.amp2_cal[prox_afe_pkg::AC_MODE];
    analog_ctrl.amp_second_cal_ref        = state_r.regs.amp2_cal[prox_afe_pkg::AC_REF];
    analog_ctrl.amp_second_trim           = state_r.regs.amp2_cal[5:0];
    analog_ctrl.comparator_cal_mode       = state_r.regs.cmp_cal[prox_afe_pkg::CC_MODE];
    analog_ctrl.comparator_cal_ref_select = state_r.regs.cmp_cal[prox_afe_pkg::CC_REF];
    analog_ctrl.comparator_trim           = state_r.regs.cmp_cal[4:0];
  end

  assign amp_second_out_oe_n = ~state_r.regs.ctrl0[prox_afe_pkg::C0_AMP2_EN];
  assign amp_first_out_oe_n  = ~state_r.regs.ctrl0[prox_afe_pkg::C0_AMP1_EN];
  assign dac_out_oe_n        = ~cmp_en;
  assign comparator_result   = state_r.filt;
  assign proximity_irq       = state_r.irq;
  assign timer_capture_input = state_r.filt & state_r.regs.capture_source_select;

endmodule : proximity_afe_control

`default_nettype wire

// ===== bench/proximity_afe_control_chk.sv
// Checker: port-level properties of the proximity front end
`timescale 1ns/1ps
`default_nettype none

module proximity_afe_control_chk (
  input wire logic                        ref_clk,              // System clock
  input wire logic                        resetn,               // Async reset, active low
  input wire logic                        avs_read,             // Read request
  input wire logic                        avs_write,            // Write request
  input wire logic                        avs_waitrequest,      // Stall
  input wire logic [7:0]                  switch_c_close,       // Bank C switches
  input wire logic [4:0]                  switch_d_close,       // Bank D switches
  input wire prox_afe_pkg::analog_ctrl_t  analog_ctrl,          // Analog settings
  input wire logic                        amp_first_out_oe_n,   // First amp pin enable
  input wire logic                        amp_second_out_oe_n,  // Second amp pin enable
  input wire logic                        dac_out_oe_n,         // DAC output enable
  input wire logic                        comparator_result,    // Filtered decision
  input wire logic                        proximity_irq,        // Edge pulse
  input wire logic                        timer_capture_input   // Capture route
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_bus_one_wait: assert property (
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait state too long");
  a_amp2_pin_off: assert property (
    amp_second_out_oe_n == !analog_ctrl.amp_second_enable) else $error("second amp pin enable wrong");
  a_amp1_pin_off: assert property (
    amp_first_out_oe_n == !analog_ctrl.amp_first_enable) else $error("first amp pin enable wrong");
  a_dac_pin_off: assert property (
    dac_out_oe_n == !analog_ctrl.comparator_dac_enable) else $error("DAC output enable wrong");
  a_irq_on_change: assert property (
    proximity_irq |-> $past(comparator_result) != $past(comparator_result, 2)) else $error("irq without edge");
  a_capture_follows: assert property (
    timer_capture_input |-> comparator_result) else $error("capture input without decision");
  a_switch_reset: assert property (
    $rose(resetn) |-> switch_c_close == 8'h00 && switch_d_close == 5'h00) else $error("switches not open");
  a_trim_reset: assert property (
    $rose(resetn) |-> analog_ctrl.amp_first_trim == 6'h20 && analog_ctrl.amp_second_trim == 6'h20
      && analog_ctrl.comparator_trim == 5'h10) else $error("trim reset value wrong");
  a_dac_reset: assert property (
    $rose(resetn) |-> analog_ctrl.dac_code == 8'h00) else $error("DAC code reset wrong");

  c_irq: cover property (proximity_irq);
  c_capture: cover property (timer_capture_input);
  c_amp_cal: cover property (analog_ctrl.amp_first_cal_mode && !amp_first_out_oe_n);
endmodule : proximity_afe_control_chk

bind proximity_afe_control proximity_afe_control_chk u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .switch_c_close(switch_c_close), .switch_d_close(switch_d_close),
  .analog_ctrl(analog_ctrl), .amp_first_out_oe_n(amp_first_out_oe_n), .amp_second_out_oe_n(amp_second_out_oe_n),
  .dac_out_oe_n(dac_out_oe_n), .comparator_result(comparator_result), .proximity_irq(proximity_irq),
  .timer_capture_input(timer_capture_input));

`default_nettype wire

// ===== bench/prox_analog_model.sv
// Behavioural analog chain: comparator and amplifier outputs
`timescale 1ns/1ps
`default_nettype none

module prox_analog_model #(
  parameter logic [5:0] AMP_TH = 6'h17,   // Trim at which amp output flips
  parameter logic [4:0] CMP_TH = 5'h09    // Trim at which comparator flips
) (
  input wire prox_afe_pkg::analog_ctrl_t  ctrl,                // Settings from the block
  input wire logic                        sense_hi,            // Sensed input above reference
  output logic                            comparator_raw,      // Comparator decision
  output logic                            amp_first_cal_out,   // First amp output
  output logic                            amp_second_cal_out   // Second amp output
);
  // Trim crossing stands in for the offset null; disabled parts read low
  assign comparator_raw = ctrl.comparator_dac_enable &
    (ctrl.comparator_cal_mode ? ctrl.comparator_trim >= CMP_TH : sense_hi);
  assign amp_first_cal_out = ctrl.amp_first_enable & (ctrl.amp_first_trim >= AMP_TH);
  assign amp_second_cal_out = ctrl.amp_second_enable & (ctrl.amp_second_trim >= AMP_TH);
endmodule : prox_analog_model

`default_nettype wire

// ===== bench/proximity_afe_control_tb.sv
// Testbench: register table, filter, interrupt edges and trim search
`timescale 1ns/1ps
`default_nettype none

module proximity_afe_control_tb;
  typedef struct packed {logic [3:0] idx; logic [7:0] wd; logic [7:0] exp;} row_t;
  localparam logic [5:0] AMP_TH = 6'h17;
  localparam logic [4:0] CMP_TH = 5'h09;
  logic ref_clk = 1'b0, resetn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sense_hi = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'h0;
  logic [1:0] avs_response, rsp;
  logic [7:0] switch_c_close;
  logic [4:0] switch_d_close;
  prox_afe_pkg::analog_ctrl_t analog_ctrl;
  logic avs_waitrequest, amp_first_out_oe_n, amp_second_out_oe_n, dac_out_oe_n, comparator_raw;
  logic amp_first_cal_out, amp_second_cal_out, comparator_result, proximity_irq, timer_capture_input;
  int errors = 0, samples_checked = 0, irq_cnt = 0, cycles = 0, lat, lo, hi;
  row_t rows[9] = '{'{4'h0, 8'hff, 8'hff}, '{4'h1, 8'hff, 8'h1f}, '{4'h3, 8'hff, 8'h3f}, '{4'h4, 8'ha5, 8'ha5},
    '{4'h5, 8'hc1, 8'hc1}, '{4'h6, 8'h7f, 8'h7f}, '{4'h7, 8'hff, 8'h7f}, '{4'h8, 8'h01, 8'h01}, '{4'h9, 8'hff, 8'h00}};
  logic [7:0] rst_val[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20, 8'h10};

  proximity_afe_control u_proximity_afe_control (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .switch_c_close(switch_c_close), .switch_d_close(switch_d_close), .analog_ctrl(analog_ctrl),
    .amp_first_out_oe_n(amp_first_out_oe_n), .amp_second_out_oe_n(amp_second_out_oe_n),
    .dac_out_oe_n(dac_out_oe_n), .comparator_raw(comparator_raw), .amp_first_cal_out(amp_first_cal_out),
    .amp_second_cal_out(amp_second_cal_out), .comparator_result(comparator_result),
    .proximity_irq(proximity_irq), .timer_capture_input(timer_capture_input));
  prox_analog_model #(.AMP_TH(AMP_TH), .CMP_TH(CMP_TH)) u_prox_analog_model (.ctrl(analog_ctrl), .sense_hi(sense_hi),
    .comparator_raw(comparator_raw), .amp_first_cal_out(amp_first_cal_out), .amp_second_cal_out(amp_second_cal_out));

  always #50 ref_clk = ~ref_clk;

  task give_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Ceiling well above the longest filter sweep and trim search
  always @(posedge ref_clk) begin
    cycles++;
    if (proximity_irq === 1'b1) irq_cnt++;
    if (cycles == 30000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d, input logic be);
    @(posedge ref_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'b000, be};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    bus(1'b1, i, d, 1'b1);
  endtask : wr

  task automatic rdchk(input logic [3:0] i, input logic [7:0] e);
    bus(1'b0, i, 8'h00, 1'b1);
    chk("readback", rd, {24'h0, e});
  endtask : rdchk

  // Synchroniser needs settling before the status bit is read
  task automatic probe(input logic [3:0] i, input logic [7:0] d, input logic [3:0] ri, input int p, output logic v);
    wr(i, d);
    repeat (4) @(posedge ref_clk);
    bus(1'b0, ri, 8'h00, 1'b1);
    v = rd[p];
  endtask : probe

  // Ascend from zero, then descend from all ones, until the status bit toggles
  task automatic trim_search(input logic [3:0] i, input logic [7:0] head, input int top, input logic [3:0] ri,
                             input int p, output int lo, output int hi);
    logic v0, v;
    probe(i, head, ri, p, v0);
    lo = 0;
    do begin
      lo++;
      probe(i, head | 8'(lo), ri, p, v);
    end while (v === v0 && lo < top);
    probe(i, head | 8'(top), ri, p, v0);
    hi = top;
    do begin
      hi--;
      probe(i, head | 8'(hi), ri, p, v);
    end while (v === v0 && hi > 0);
  endtask : trim_search

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rdchk(rows[i].idx, rows[i].exp);
    end
    chk("response", 32'(rsp), 32'h2);
    chk("ctrl_hi", 32'(analog_ctrl[39:32]), 32'h1f);
    chk("ctrl_lo", analog_ctrl[31:0], {1'b1, 8'ha5, 8'hc1, 8'h7f, 7'h7f});
    chk("switches", {19'h0, switch_d_close, switch_c_close}, 32'h1fff);
    bus(1'b1, 4'h4, 8'h00, 1'b0);
    rdchk(4'h4, 8'ha5);
    wr(4'h7, 8'h10);
    wr(4'h2, 8'he0);
    chk("pin_enables", 32'({amp_first_out_oe_n, amp_second_out_oe_n, dac_out_oe_n}), 32'h0);
    for (int n = 0; n < 8; n++) begin
      wr(4'h2, {5'b11100, 3'(n)});
      sense_hi <= 1'b1;
      lat = 0;
      while (comparator_result !== 1'b1) begin
        @(posedge ref_clk);
        lat++;
      end
      chk("deb_min", 32'(lat >= (1 << n) + 2), 32'h1);
      chk("deb_max", 32'(lat <= (1 << n) + 8), 32'h1);
      sense_hi <= 1'b0;
      while (comparator_result !== 1'b0) @(posedge ref_clk);
    end
    wr(4'h2, 8'hea);
    irq_cnt = 0;
    sense_hi <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sense_hi <= 1'b0;
    repeat (20) @(posedge ref_clk);
    chk("glitch_irq", 32'(irq_cnt), 32'h0);
    for (int e = 0; e < 4; e++) begin
      wr(4'h2, {3'b111, 2'(e), 3'b001});
      irq_cnt = 0;
      sense_hi <= 1'b1;
      repeat (20) @(posedge ref_clk);
      chk("capture", 32'(timer_capture_input), 32'h1);
      rdchk(4'h7, 8'h90);
      sense_hi <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk("irq_count", 32'(irq_cnt), 32'(e % 2 + e / 2));
    end
    sense_hi <= 1'b1;
    wr(4'h2, 8'h00);
    repeat (10) @(posedge ref_clk);
    rdchk(4'h7, 8'h10);
    chk("dac_off", 32'({dac_out_oe_n, comparator_result}), 32'h2);
    sense_hi <= 1'b0;
    wr(4'h2, 8'h40);
    wr(4'h5, 8'h80);
    trim_search(4'h5, 8'hc0, 63, 4'h3, 6, lo, hi);
    wr(4'h5, 8'hc0 | 8'((lo + hi) / 2));
    rdchk(4'h5, {2'b11, AMP_TH - 6'h01});
    wr(4'h2, 8'h20);
    wr(4'h7, 8'h40);
    trim_search(4'h7, 8'h60, 31, 4'h7, 7, lo, hi);
    wr(4'h7, 8'h60 | 8'((lo + hi) / 2));
    rdchk(4'h7, {3'b011, CMP_TH - 5'h01});
    resetn <= 1'b0;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(4'(i), rst_val[i]);
    give_verdict();
  end
endmodule : proximity_afe_control_tb

`default_nettype wire
